// ===== idr_pkg.sv
// Shared constants and types for the idle ladder and firmware RAM block.
// Assumes a single 20 MHz system clock in both ends.
package idr_pkg;
    localparam int unsigned SYS_CLK_HZ   = 20_000_000;
    localparam int unsigned TICK_MS      = 10;
    localparam int unsigned TICK_CYC     = SYS_CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned CRC_WAIT_MS  = 10;
    localparam int unsigned CRC_WAIT_CYC = SYS_CLK_HZ / 1000 * CRC_WAIT_MS;
    localparam int unsigned HWRST_CYC    = 4;
    localparam int unsigned IDLE1_MULT   = 16;
    localparam int unsigned IDLE2_MULT   = 32;

    localparam logic [6:0] OFF_MOTION    = 7'h02;
    localparam logic [6:0] OFF_CONFIG    = 7'h10;
    localparam logic [6:0] OFF_SNAPSHOT  = 7'h12;
    localparam logic [6:0] OFF_FW_CTRL   = 7'h13;
    localparam logic [6:0] OFF_RUN_DLY   = 7'h14;
    localparam logic [6:0] OFF_IDLE1_PER = 7'h15;
    localparam logic [6:0] OFF_IDLE1_DLY = 7'h16;
    localparam logic [6:0] OFF_IDLE2_PER = 7'h17;
    localparam logic [6:0] OFF_IDLE2_DLY = 7'h18;
    localparam logic [6:0] OFF_IDLE3_PER = 7'h19;
    localparam logic [6:0] OFF_DATA_LO   = 7'h25;
    localparam logic [6:0] OFF_DATA_HI   = 7'h26;

    localparam logic [7:0] RST_CONFIG    = 8'h00;
    localparam logic [7:0] RST_SNAPSHOT  = 8'h00;
    localparam logic [7:0] RST_RUN_DLY   = 8'h32;
    localparam logic [7:0] RST_IDLE1_PER = 8'h01;
    localparam logic [7:0] RST_IDLE1_DLY = 8'h1F;
    localparam logic [7:0] RST_IDLE2_PER = 8'h09;
    localparam logic [7:0] RST_IDLE2_DLY = 8'hBC;
    localparam logic [7:0] RST_IDLE3_PER = 8'h31;

    localparam int unsigned FORCE_LSB    = 6;
    localparam int unsigned IDLE_EN_BIT  = 5;
    localparam int unsigned MOTION_BIT   = 7;
    localparam int unsigned FAULT_BIT    = 6;

    localparam logic [7:0] FW_CMD_CRC    = 8'h15;
    localparam logic [7:0] FW_CMD_LOAD   = 8'h1D;
    localparam logic [15:0] CRC_SEED     = 16'hFFFF;
    localparam logic [15:0] CRC_POLY     = 16'h1021;

    localparam logic [7:0] CTL_CMD       = 8'h00;
    localparam logic [7:0] CTL_ARG       = 8'h04;
    localparam logic [7:0] CTL_STATUS    = 8'h08;
    localparam logic [7:0] CTL_CRC       = 8'h0C;

    typedef enum logic [1:0] {
        LVL_RUN   = 2'b00,
        LVL_IDLE1 = 2'b01,
        LVL_IDLE2 = 2'b10,
        LVL_IDLE3 = 2'b11
    } idr_level_type;

    typedef enum logic [2:0] {
        OP_NONE  = 3'b000,
        OP_WRITE = 3'b001,
        OP_READ  = 3'b010,
        OP_SNAP  = 3'b011,
        OP_CRC   = 3'b100,
        OP_LOAD  = 3'b101,
        OP_HWRST = 3'b110
    } idr_op_type;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_REQ  = 3'b001,
        H_RSP  = 3'b010,
        H_WAIT = 3'b011,
        H_RST  = 3'b100
    } idr_hstate_type;
endpackage

// ===== idr_link_if.sv
// Register link between the sensor core and its controller.
// Assumes both ends run on the same sys_clk; the bench joins them.
`timescale 1ns/1ps
`default_nettype none
interface idr_link_if;
    logic       req;
    logic       we;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic       rsp;
    logic [7:0] rdata;
    logic       hw_reset;
    modport dev (input req, we, addr, wdata, hw_reset, output rsp, rdata);
    modport ctl (output req, we, addr, wdata, hw_reset, input rsp, rdata);
endinterface
`default_nettype wire

// ===== idr_sensor_core.sv
// Sensor end: idle ladder, snapshot capture, firmware RAM download and CRC.
// Assumes synchronous pixel and motion inputs and one request at a time.
// How it works
// - Snapshot write captures next full frame to RAM.
// - Snapshot overwrites firmware and halts tracking.
// - Controller resets and reloads after a snapshot.
// - Firmware control write starts download or CRC.
// - Controller runs CRC only after a download.
// - CRC halts tracking; no link traffic meanwhile.
// - Controller writes 0x15, waits 10 ms, reads CRC.
// - Controller checks laser fault before CRC.
// - Run to idle one after delay times 10 ms.
// - Run downshift timed from system clock.
// - Idle one period is (rate+1) times 10 ms.
// - Idle one to two after delay*16 periods.
// - Idle two period is (rate+1) times 10 ms.
// - Idle two to three delay register, default 0xBC.
// - Idle timing uses 100 Hz hibernate tick.
// - Idle two to three after delay*32 periods.
// - Idle three period (rate+1)*10 ms, stays there.
// - Idle ladder only while idle enable set.
// - Force code holds idle level, resumes after.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module idr_sensor_core
    import idr_pkg::*;
#(
    parameter int unsigned RUN_TICK_CYC = TICK_CYC,
    parameter int unsigned HIB_TICK_CYC = TICK_CYC,
    parameter int unsigned RAM_DEPTH    = 64
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    // Link to the controller
    idr_link_if.dev         link,
    // Sensor front end
    input  wire logic       motion_det,
    input  wire logic       laser_fault,
    input  wire logic       pix_valid,
    input  wire logic       pix_first,
    input  wire logic [7:0] pix_data,
    // Status
    output logic [1:0]      idle_level,
    output logic            sample_pulse,
    output logic            tracking_on,
    output logic            snapshot_done,
    output logic            download_active,
    output logic            crc_busy
);
    localparam int unsigned AW = $clog2(RAM_DEPTH);
    localparam logic [AW-1:0] LAST = AW'(RAM_DEPTH - 1);

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    logic [7:0]    ram [RAM_DEPTH];
    logic [7:0]    config_ff, snap_reg_ff, run_dly_ff, p1_ff, d1_ff, p2_ff, d2_ff, p3_ff;
    logic          halt_ff, arm_ff, cap_ff, crc_ff, load_ff, done_ff;
    logic [AW-1:0] cap_ptr_ff, crc_ptr_ff;
    logic [15:0]   crc_acc_ff, crc_res_ff;
    logic          rsp_ff;
    logic [7:0]    rdata_ff;
    logic [31:0]   run_div_ff, hib_div_ff;
    logic          run_tick, hib_tick;
    idr_level_type lvl_ff, nxt_lvl;
    logic [7:0]    run_cnt_ff;
    logic [8:0]    per_cnt_ff;
    logic [12:0]   frm_cnt_ff;
    logic          sample_ff, period_end;
    logic [7:0]    cur_per;
    logic          clr, wr, rd;
    logic [1:0]    force_code;

    assign clr        = link.hw_reset;
    assign wr         = link.req && link.we && !crc_ff;
    assign rd         = link.req && !link.we;
    assign force_code = config_ff[FORCE_LSB +: 2];

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            {config_ff, snap_reg_ff, run_dly_ff, p1_ff, d1_ff, p2_ff, d2_ff, p3_ff} <= {RST_CONFIG, RST_SNAPSHOT,
                RST_RUN_DLY, RST_IDLE1_PER, RST_IDLE1_DLY, RST_IDLE2_PER, RST_IDLE2_DLY, RST_IDLE3_PER};
        end else if (clr) begin
            {config_ff, snap_reg_ff, run_dly_ff, p1_ff, d1_ff, p2_ff, d2_ff, p3_ff} <= {RST_CONFIG, RST_SNAPSHOT,
                RST_RUN_DLY, RST_IDLE1_PER, RST_IDLE1_DLY, RST_IDLE2_PER, RST_IDLE2_DLY, RST_IDLE3_PER};
        end else if (wr) begin
            unique case (link.addr)
                OFF_CONFIG:    config_ff   <= link.wdata;
                OFF_SNAPSHOT:  snap_reg_ff <= link.wdata;
                OFF_RUN_DLY:   run_dly_ff  <= link.wdata;
                OFF_IDLE1_PER: p1_ff       <= link.wdata;
                OFF_IDLE1_DLY: d1_ff       <= link.wdata;
                OFF_IDLE2_PER: p2_ff       <= link.wdata;
                OFF_IDLE2_DLY: d2_ff       <= link.wdata;
                OFF_IDLE3_PER: p3_ff       <= link.wdata;
                default: ;
            endcase
        end
    end

    // A read during the CRC still answers so the link never hangs.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            {rsp_ff, rdata_ff} <= '0;
        end else begin
            rsp_ff <= link.req;
            if (rd) begin
                unique case (link.addr)
                    OFF_MOTION:    rdata_ff <= 8'(({7'h00, motion_det} << MOTION_BIT)
                                                 | ({7'h00, laser_fault} << FAULT_BIT));
                    OFF_CONFIG:    rdata_ff <= config_ff;
                    OFF_SNAPSHOT:  rdata_ff <= snap_reg_ff;
                    OFF_RUN_DLY:   rdata_ff <= run_dly_ff;
                    OFF_IDLE1_PER: rdata_ff <= p1_ff;
                    OFF_IDLE1_DLY: rdata_ff <= d1_ff;
                    OFF_IDLE2_PER: rdata_ff <= p2_ff;
                    OFF_IDLE2_DLY: rdata_ff <= d2_ff;
                    OFF_IDLE3_PER: rdata_ff <= p3_ff;
                    OFF_DATA_LO:   rdata_ff <= crc_res_ff[7:0];
                    OFF_DATA_HI:   rdata_ff <= crc_res_ff[15:8];
                    default:       rdata_ff <= 8'h00;
                endcase
            end
        end
    end

    // Snapshot: arm on the write, start at the next frame's first pixel.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            {halt_ff, arm_ff, cap_ff, done_ff, cap_ptr_ff} <= '0;
        end else if (clr) begin
            {halt_ff, arm_ff, cap_ff, done_ff, cap_ptr_ff} <= '0;
        end else begin
            if (wr && link.addr == OFF_SNAPSHOT) begin
                halt_ff <= 1'b1;
                arm_ff  <= 1'b1;
                done_ff <= 1'b0;
            end else if (arm_ff && pix_valid && pix_first) begin
                arm_ff     <= 1'b0;
                cap_ff     <= 1'b1;
                cap_ptr_ff <= AW'(1);
            end else if (cap_ff && pix_valid) begin
                cap_ptr_ff <= cap_ptr_ff + AW'(1);
                if (cap_ptr_ff == LAST) begin
                    cap_ff  <= 1'b0;
                    done_ff <= 1'b1;
                end
            end
        end
    end

    // The frame overwrites whatever firmware the RAM held.
    always_ff @(posedge sys_clk) begin
        if (arm_ff && pix_valid && pix_first) begin
            ram['0] <= pix_data;
        end else if (cap_ff && pix_valid) begin
            ram[cap_ptr_ff] <= pix_data;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            {load_ff, crc_ff, crc_ptr_ff, crc_res_ff} <= '0;
            crc_acc_ff <= CRC_SEED;
        end else if (clr) begin
            {load_ff, crc_ff, crc_ptr_ff} <= '0;
            crc_acc_ff <= CRC_SEED;
        end else if (crc_ff) begin
            crc_acc_ff <= crc_byte(crc_acc_ff, ram[crc_ptr_ff]);
            crc_ptr_ff <= crc_ptr_ff + AW'(1);
            if (crc_ptr_ff == LAST) begin
                crc_ff     <= 1'b0;
                crc_res_ff <= crc_byte(crc_acc_ff, ram[crc_ptr_ff]);
            end
        end else if (wr && link.addr == OFF_FW_CTRL) begin
            if (link.wdata == FW_CMD_CRC) begin
                crc_ff     <= 1'b1;
                crc_ptr_ff <= '0;
                crc_acc_ff <= CRC_SEED;
            end else if (link.wdata == FW_CMD_LOAD) begin
                load_ff <= 1'b1;
            end
        end
    end

    // Two separate dividers for run and hibernate timing; with equal periods they tick together.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            run_div_ff <= '0;
            hib_div_ff <= '0;
        end else begin
            run_div_ff <= run_tick ? '0 : run_div_ff + 32'h0000_0001;
            hib_div_ff <= hib_tick ? '0 : hib_div_ff + 32'h0000_0001;
        end
    end
    assign run_tick = (run_div_ff == 32'(RUN_TICK_CYC - 1));
    assign hib_tick = (hib_div_ff == 32'(HIB_TICK_CYC - 1));

    always_comb begin
        unique case (lvl_ff)
            LVL_IDLE1: cur_per = p1_ff;
            LVL_IDLE2: cur_per = p2_ff;
            default:   cur_per = p3_ff;
        endcase
    end
    assign period_end = hib_tick && (per_cnt_ff == {1'b0, cur_per});

    always_comb begin
        nxt_lvl = lvl_ff;
        if (force_code != 2'b00) begin
            nxt_lvl = idr_level_type'(force_code);
        end else if (!config_ff[IDLE_EN_BIT] || motion_det) begin
            nxt_lvl = LVL_RUN;
        end else begin
            unique case (lvl_ff)
                LVL_RUN:   if (run_cnt_ff >= run_dly_ff) nxt_lvl = LVL_IDLE1;
                LVL_IDLE1: if (frm_cnt_ff >= 13'(d1_ff * IDLE1_MULT)) nxt_lvl = LVL_IDLE2;
                LVL_IDLE2: if (frm_cnt_ff >= 13'(d2_ff * IDLE2_MULT)) nxt_lvl = LVL_IDLE3;
                LVL_IDLE3: nxt_lvl = LVL_IDLE3;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            lvl_ff <= LVL_RUN;
            {run_cnt_ff, per_cnt_ff, frm_cnt_ff, sample_ff} <= '0;
        end else if (clr) begin
            lvl_ff <= LVL_RUN;
            {run_cnt_ff, per_cnt_ff, frm_cnt_ff, sample_ff} <= '0;
        end else begin
            lvl_ff    <= nxt_lvl;
            sample_ff <= (lvl_ff != LVL_RUN) && (nxt_lvl == lvl_ff) && period_end;
            if (nxt_lvl != lvl_ff || motion_det) begin
                {run_cnt_ff, per_cnt_ff, frm_cnt_ff} <= '0;
            end else if (lvl_ff == LVL_RUN) begin
                if (run_tick && run_cnt_ff != 8'hFF) run_cnt_ff <= run_cnt_ff + 8'h01;
            end else if (period_end) begin
                per_cnt_ff <= 9'h000;
                if (frm_cnt_ff != 13'h1FFF) frm_cnt_ff <= frm_cnt_ff + 13'h0001;
            end else if (hib_tick) begin
                per_cnt_ff <= per_cnt_ff + 9'h001;
            end
        end
    end

    assign link.rsp        = rsp_ff;
    assign link.rdata      = rdata_ff;
    assign idle_level      = lvl_ff;
    assign sample_pulse    = sample_ff;
    assign snapshot_done   = done_ff;
    assign download_active = load_ff;
    assign crc_busy        = crc_ff;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) tracking_on <= 1'b1;
        else          tracking_on <= !halt_ff && !crc_ff && !clr && !(wr && link.addr == OFF_SNAPSHOT);
    end
endmodule
`default_nettype wire

// ===== idr_host_ctrl.sv
// Controller end: runs link sequences ordered over a Wishbone slave.
// Assumes a classic Wishbone master on the same sys_clk.
`timescale 1ns/1ps
`default_nettype none
module idr_host_ctrl
    import idr_pkg::*;
#(
    parameter int unsigned CRC_WAIT = CRC_WAIT_CYC
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Link to the sensor
    idr_link_if.ctl          link
);
    idr_hstate_type st_ff;
    idr_op_type     op_ff;
    logic [1:0]     step_ff;
    logic [14:0]    arg_ff;
    logic [7:0]     rd_ff;
    logic [15:0]    crc_ff;
    logic           err_ff, reload_ff, rst_seen_ff, loaded_ff;
    logic           ack_ff, req_ff, we_ff, hwr_ff;
    logic [31:0]    dat_ff, wait_ff;
    logic [6:0]     addr_ff;
    logic [7:0]     wdata_ff;
    logic           bus, cmd_go;
    idr_op_type     cmd_op;

    assign bus    = wb_cyc_i && wb_stb_i;
    assign cmd_op = idr_op_type'(wb_dat_i[2:0]);
    assign cmd_go = bus && ack_ff && wb_we_i && wb_sel_i[0] && wb_adr_i == CTL_CMD && st_ff == H_IDLE;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_ff <= 1'b0;
            dat_ff <= '0;
            arg_ff <= 15'h0000;
        end else begin
            ack_ff <= bus && !ack_ff;
            if (bus && !ack_ff) begin
                unique case (wb_adr_i)
                    CTL_ARG:    dat_ff <= {17'h0, arg_ff};
                    CTL_STATUS: dat_ff <= {16'h0, rd_ff, 4'h0, loaded_ff, reload_ff, err_ff, st_ff != H_IDLE};
                    CTL_CRC:    dat_ff <= {16'h0, crc_ff};
                    default:    dat_ff <= '0;
                endcase
            end
            if (bus && ack_ff && wb_we_i && wb_adr_i == CTL_ARG) begin
                if (wb_sel_i[0]) arg_ff[7:0]  <= wb_dat_i[7:0];
                if (wb_sel_i[1]) arg_ff[14:8] <= wb_dat_i[14:8];
            end
        end
    end
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= H_IDLE; op_ff <= OP_NONE; step_ff <= 2'b00;
            req_ff <= 1'b0; we_ff <= 1'b0; addr_ff <= 7'h00; wdata_ff <= 8'h00;
            hwr_ff <= 1'b0; wait_ff <= '0; rd_ff <= 8'h00; crc_ff <= 16'h0000;
            err_ff <= 1'b0; reload_ff <= 1'b0; rst_seen_ff <= 1'b0; loaded_ff <= 1'b0;
        end else begin
            req_ff <= 1'b0;
            unique case (st_ff)
                H_IDLE: if (cmd_go) begin
                    op_ff <= cmd_op; step_ff <= 2'b00; err_ff <= 1'b0;
                    st_ff <= H_REQ; we_ff <= 1'b1; wdata_ff <= 8'h00;
                    unique case (cmd_op)
                        OP_WRITE: begin addr_ff <= arg_ff[14:8]; wdata_ff <= arg_ff[7:0]; end
                        OP_READ: begin
                            we_ff <= 1'b0; addr_ff <= arg_ff[14:8];
                            if (reload_ff && arg_ff[14:8] == OFF_MOTION) begin
                                err_ff <= 1'b1; st_ff <= H_IDLE;
                            end
                        end
                        OP_SNAP: begin addr_ff <= OFF_SNAPSHOT; reload_ff <= 1'b1; rst_seen_ff <= 1'b0; loaded_ff <= 1'b0; end
                        OP_LOAD: begin addr_ff <= OFF_FW_CTRL; wdata_ff <= FW_CMD_LOAD; end
                        OP_CRC: begin
                            we_ff <= 1'b0; addr_ff <= OFF_MOTION;
                            if (!loaded_ff) begin err_ff <= 1'b1; st_ff <= H_IDLE; end
                        end
                        OP_HWRST: begin st_ff <= H_RST; hwr_ff <= 1'b1; wait_ff <= '0; end
                        default: st_ff <= H_IDLE;
                    endcase
                end
                H_REQ: begin req_ff <= 1'b1; st_ff <= H_RSP; end
                H_RSP: if (link.rsp) begin
                    st_ff <= H_IDLE;
                    if (!we_ff) rd_ff <= link.rdata;
                    if (op_ff == OP_LOAD) begin
                        loaded_ff <= 1'b1;
                        if (rst_seen_ff) reload_ff <= 1'b0;
                    end
                    if (op_ff == OP_CRC) begin
                        unique case (step_ff)
                            2'b00: if (link.rdata[FAULT_BIT]) err_ff <= 1'b1;
                                   else begin step_ff <= 2'b01; we_ff <= 1'b1; addr_ff <= OFF_FW_CTRL;
                                              wdata_ff <= FW_CMD_CRC; st_ff <= H_REQ; end
                            2'b01: begin step_ff <= 2'b10; st_ff <= H_WAIT; wait_ff <= '0; end
                            2'b10: begin crc_ff[7:0] <= link.rdata; step_ff <= 2'b11;
                                         addr_ff <= OFF_DATA_HI; st_ff <= H_REQ; end
                            2'b11: crc_ff[15:8] <= link.rdata;
                        endcase
                    end
                end
                H_WAIT: begin
                    wait_ff <= wait_ff + 32'h0000_0001;
                    if (wait_ff == 32'(CRC_WAIT - 1)) begin
                        we_ff <= 1'b0; addr_ff <= OFF_DATA_LO; st_ff <= H_REQ;
                    end
                end
                H_RST: begin
                    wait_ff <= wait_ff + 32'h0000_0001;
                    if (wait_ff == 32'(HWRST_CYC - 1)) begin
                        hwr_ff <= 1'b0; rst_seen_ff <= 1'b1; loaded_ff <= 1'b0; st_ff <= H_IDLE;
                    end
                end
                default: st_ff <= H_IDLE;
            endcase
        end
    end

    assign link.req      = req_ff;
    assign link.we       = we_ff;
    assign link.addr     = addr_ff;
    assign link.wdata    = wdata_ff;
    assign link.hw_reset = hwr_ff;
endmodule
`default_nettype wire

// ===== idr_sva.sv
// Link checker for both ends.
// Assumes one clock; the bench places it beside the link.
`timescale 1ns/1ps
`default_nettype none
module idr_sva
    import idr_pkg::*;
#(parameter int unsigned CRC_WAIT = 100) (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       reset_n,
    // Link
    input wire logic       req,
    input wire logic       we,
    input wire logic [6:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       rsp,
    input wire logic       hw_reset
);
    logic        crc_w;
    logic        ld_ff;
    logic        snap_ff;
    logic        mot_ff;
    int unsigned wt_ff;
    assign crc_w = req && we && addr == OFF_FW_CTRL && wdata == FW_CMD_CRC;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // The wait count saturates so a long quiet spell never wraps.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) wt_ff <= CRC_WAIT;
        else if (crc_w) wt_ff <= 0;
        else if (wt_ff < CRC_WAIT) wt_ff <= wt_ff + 1;
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) {ld_ff, snap_ff, mot_ff} <= 3'h0;
        else begin
            if (req) mot_ff <= !we && addr == OFF_MOTION;
            if (hw_reset) {ld_ff, snap_ff} <= 2'h0;
            else if (req && we && addr == OFF_SNAPSHOT) {ld_ff, snap_ff} <= 2'h1;
            else if (req && we && addr == OFF_FW_CTRL && wdata == FW_CMD_LOAD) ld_ff <= 1'h1;
        end
    end
    property p_rsp_next; req |=> rsp && !req; endproperty
    a_rsp_next: assert property (p_rsp_next) else $error("link answer missing");
    property p_rsp_cause; rsp |-> $past(req); endproperty
    a_rsp_cause: assert property (p_rsp_cause) else $error("link answer without request");
    property p_hw_rst; $rose(hw_reset) |-> hw_reset[*4] ##1 !hw_reset; endproperty
    a_hw_rst: assert property (p_hw_rst) else $error("hardware reset length wrong");
    property p_crc_quiet; req && !crc_w |-> wt_ff + 1 >= CRC_WAIT; endproperty
    a_crc_quiet: assert property (p_crc_quiet) else $error("link used during self-check");
    property p_load_first; crc_w |-> ld_ff; endproperty
    a_load_first: assert property (p_load_first) else $error("self-check without download");
    property p_fault_first; crc_w |-> mot_ff; endproperty
    a_fault_first: assert property (p_fault_first) else $error("fault not read first");
    property p_snap_quiet; req && !we && addr == OFF_MOTION |-> !snap_ff; endproperty
    a_snap_quiet: assert property (p_snap_quiet) else $error("motion read after snapshot");
    property p_crc_pair; req && !we && addr == OFF_DATA_LO |-> ##[2:8] (req && !we && addr == OFF_DATA_HI); endproperty
    a_crc_pair: assert property (p_crc_pair) else $error("result upper byte not read");
endmodule
`default_nettype wire

// ===== idr_bench.sv
// Bench joining both ends, driving Wishbone and pixels.
// Assumes shortened ticks of 10 cycles and a self-check wait of 100.
`timescale 1ns/1ps
`default_nettype none
module idr_bench
    import idr_pkg::*;
;
    logic        sys_clk, reset_n, cyc, stb, we, mot, pv, pf, ack, trk, sd, flt;
    logic [7:0]  adr, pd, r;
    logic [31:0] dat, dout, last;
    logic [1:0]  lvl;
    logic [15:0] crc;
    logic [63:0] q[$];
    int          miscompares, total_checks, seed, n;
    idr_link_if lk();
    idr_sensor_core #(.RUN_TICK_CYC(10), .HIB_TICK_CYC(10)) i_idr_sensor_core(.sys_clk, .reset_n, .link(lk),
        .motion_det(mot), .laser_fault(flt), .pix_valid(pv), .pix_first(pf), .pix_data(pd), .idle_level(lvl),
        .sample_pulse(), .tracking_on(trk), .snapshot_done(sd), .download_active(), .crc_busy());
    idr_host_ctrl #(.CRC_WAIT(100)) i_idr_host_ctrl(.sys_clk, .reset_n, .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_dat_o(dout), .wb_ack_o(ack), .link(lk));
    idr_sva #(.CRC_WAIT(100)) i_idr_sva(.sys_clk, .reset_n, .req(lk.req), .we(lk.we), .addr(lk.addr),
        .wdata(lk.wdata), .rsp(lk.rsp), .hw_reset(lk.hw_reset));
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        n = 0;
        {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
        do @(posedge sys_clk); while (ack !== 1'h1 && ++n < 50);
        last = dout;
        {cyc, stb} <= 2'h0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
        q.push_back({m, e});
        wb(1'h0, a, 32'h0);
    endtask
    // Orders are polled to idle so none is dropped as busy.
    task automatic op(input idr_op_type o, input logic [6:0] a, input logic [7:0] d);
        wb(1'h1, CTL_ARG, {17'h0, a, d});
        wb(1'h1, CTL_CMD, {29'h0, o});
        do wb(1'h0, CTL_STATUS, 32'h0); while (last[0] !== 1'h0);
    endtask
    task automatic rv(input logic [6:0] a, input logic [7:0] e);
        op(OP_READ, a, 8'h00);
        rd(CTL_STATUS, 32'hFF00, {16'h0, e, 8'h00});
    endtask
    task automatic lv(input logic [1:0] l, input int lo, hi);
        n = 0;
        while (lvl !== l && n < hi) begin
            @(posedge sys_clk);
            n++;
        end
        chk("level delay", {31'h0, n >= lo && n < hi}, 32'h1);
    endtask
    function automatic logic [15:0] nc(input logic [15:0] c, input logic [7:0] b);
        c = c ^ {b, 8'h00};
        for (int k = 0; k < 8; k++) c = c[15] ? {c[14:0], 1'h0} ^ CRC_POLY : {c[14:0], 1'h0};
        return c;
    endfunction
    always @(posedge sys_clk) if (ack === 1'h1 && we === 1'h0 && q.size() > 0) begin
        chk("read data", dout & q[0][63:32], q[0][31:0]);
        void'(q.pop_front());
    end
    initial begin
        sys_clk = 1'h0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        summarize();
    end
    initial begin
        {seed, cyc, stb, we, adr, dat, mot, pv, pf, pd, flt, reset_n} = '0;
        seed = 77;
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'h1;
        @(posedge sys_clk);
        rv(OFF_SNAPSHOT, RST_SNAPSHOT);
        rv(OFF_RUN_DLY, RST_RUN_DLY);
        rv(OFF_IDLE1_PER, RST_IDLE1_PER);
        rv(OFF_IDLE1_DLY, RST_IDLE1_DLY);
        rv(OFF_IDLE2_PER, RST_IDLE2_PER);
        rv(OFF_IDLE2_DLY, RST_IDLE2_DLY);
        chk("level", {30'h0, lvl}, 32'h0);
        r = $random(seed);
        op(OP_WRITE, OFF_IDLE3_PER, r);
        rv(OFF_IDLE3_PER, r);
        {mot, flt} <= 2'h3;
        op(OP_WRITE, OFF_RUN_DLY, 8'h03);
        op(OP_WRITE, OFF_IDLE1_PER, 8'h00);
        op(OP_WRITE, OFF_IDLE1_DLY, 8'h01);
        op(OP_WRITE, OFF_IDLE2_PER, 8'h01);
        op(OP_WRITE, OFF_IDLE2_DLY, 8'h01);
        op(OP_WRITE, OFF_CONFIG, 8'h20);
        mot <= 1'h0;
        lv(LVL_IDLE1, 15, 45);
        lv(LVL_IDLE2, 145, 185);
        lv(LVL_IDLE3, 610, 680);
        mot <= 1'h1;
        lv(LVL_RUN, 0, 4);
        op(OP_WRITE, OFF_CONFIG, 8'hE0);
        lv(LVL_IDLE3, 0, 30);
        op(OP_WRITE, OFF_CONFIG, 8'h20);
        lv(LVL_RUN, 0, 30);
        op(OP_SNAP, OFF_SNAPSHOT, 8'h00);
        chk("tracking", {31'h0, trk}, 32'h0);
        crc = CRC_SEED;
        for (int i = 0; i < 67; i++) begin
            r = $random(seed);
            {pv, pf, pd} <= {1'h1, i == 3, r};
            if (i >= 3) crc = nc(crc, r);
            @(posedge sys_clk);
        end
        pv <= 1'h0;
        repeat (3) @(posedge sys_clk);
        chk("snapshot", {31'h0, sd}, 32'h1);
        op(OP_CRC, OFF_FW_CTRL, FW_CMD_CRC);
        rd(CTL_STATUS, 32'h6, 32'h6);
        op(OP_HWRST, 7'h00, 8'h00);
        op(OP_LOAD, OFF_FW_CTRL, FW_CMD_LOAD);
        op(OP_CRC, OFF_FW_CTRL, FW_CMD_CRC);
        rd(CTL_STATUS, 32'h2, 32'h2);
        flt <= 1'h0;
        op(OP_CRC, OFF_FW_CTRL, FW_CMD_CRC);
        rd(CTL_CRC, 32'hFFFF, {16'h0, crc});
        summarize();
    end
endmodule
`default_nettype wire
